/* File: pcflow_pkg.sv */
// Shared constants and types for the program-flow and indirect-address core.
// Assumes a single core clock and an APB bus with 32-bit aligned registers.
package pcflow_pkg;

  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam int LATCH_W = 5;
  localparam int DADDR_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  localparam logic [7:0] OFS_INDIRECT = 8'h00;
  localparam logic [7:0] OFS_PC_LOW = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FSEL = 8'h0C;
  localparam logic [7:0] OFS_PC_LATCH = 8'h10;
  localparam logic [7:0] OFS_PC_VIEW = 8'h14;

  localparam int STATUS_BANK_POS = 7;
  localparam int LATCH_TOP_POS = 3;

  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [LATCH_W-1:0] LATCH_RESET = 5'h00;
  localparam logic [7:0] FSEL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SELF_ADDR = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  localparam logic [1:0] ACC_WAIT = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_STEP = 3'b001,
    OP_CALL = 3'b010,
    OP_JUMP = 3'b011,
    OP_RET = 3'b100,
    OP_RETLIT = 3'b101,
    OP_RETINT = 3'b110,
    OP_INTR = 3'b111
  } flow_op_t;

endpackage

/* File: stack_if.sv */
// Interface carrying push, pop and top-of-stack between core and stack.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface stack_if;
  import pcflow_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] top;
  modport core (output push, output pop, output push_data, input top);
  modport store (input push, input pop, input push_data, output top);
endinterface

/* File: ret_stack.sv */
// Eight-entry circular return-address stack with registered top output.
// Assumes push and pop never arrive together.
`timescale 1ns/100ps
module ret_stack
  import pcflow_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  stack_if.store st
);

  logic [PC_W-1:0] mem_q [STACK_DEPTH];
  logic [PC_W-1:0] mem_d [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;
  logic [PC_W-1:0] top_q;
  logic [PC_W-1:0] top_d;

  ////////////////////////////////////////////////////////////////////////////
  // The pointer wraps silently; nothing reports overflow or underflow.
  always_comb begin
    mem_d = mem_q;
    sp_d = sp_q;
    top_d = top_q;
    if (st.push) begin
      mem_d[sp_q] = st.push_data;
      sp_d = sp_q + 3'h1;
      top_d = st.push_data;
    end else if (st.pop) begin
      sp_d = sp_q - 3'h1;
      top_d = mem_q[sp_q - 3'h2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        mem_q[i] <= PC_RESET;
      end
      sp_q <= 3'h0;
      top_q <= PC_RESET;
    end else begin
      mem_q <= mem_d;
      sp_q <= sp_d;
      top_q <= top_d;
    end
  end

  assign st.top = top_q;

endmodule

/* File: pcflow_core.sv */
// Program counter, return stack control and indirect data addressing.
// Assumes an APB master, a decoder giving one flow op per cycle, and a data
// memory that returns read data one clock after a registered read strobe.
`timescale 1ns/100ps

// Operation
// - 13-bit PC, low byte software readable/writable.
// - Software writes high PC bits only through latch.
// - Every reset clears the whole PC.
// - Low-byte write loads high bits from latch.
// - Call/jump take top two bits from latch.
// - Eight 13-bit stack entries, hidden pointer.
// - Call pushes PC plus one; interrupt branch pushes the PC.
// - Any return kind pops into the PC.
// - Push and pop leave latch untouched.
// - Stack wraps circularly, ninth push overwrites first.
// - No stack overflow or underflow status.
// - Indirect port accesses location held in pointer.
// - Pointer at indirect port reads zero.
// - Pointer at indirect port writes nothing.
// - Indirect address is bank bit plus pointer.
module pcflow_core
  import pcflow_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_valid,
  input wire flow_op_t op_code,
  input wire logic [LIT_W-1:0] op_literal,
  output logic [PC_W-1:0] pc,
  output logic [DADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  stack_if st ();

  ret_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .st(st)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic sel_ind;
  logic sel_pcl;
  logic sel_stat;
  logic sel_fsel;
  logic sel_latch;
  logic sel_view;
  logic sel_any;
  logic setup_ph;
  logic done;
  logic wr_done;
  logic ind_self;
  logic [DADDR_W-1:0] ind_addr;

  always_comb begin
    sel_ind = 1'b0;
    sel_pcl = 1'b0;
    sel_stat = 1'b0;
    sel_fsel = 1'b0;
    sel_latch = 1'b0;
    sel_view = 1'b0;
    if (paddr[31:8] != 24'h000000) begin
      sel_ind = 1'b0;
    end else if (paddr[7:0] == OFS_INDIRECT) begin
      sel_ind = 1'b1;
    end else if (paddr[7:0] == OFS_PC_LOW) begin
      sel_pcl = 1'b1;
    end else if (paddr[7:0] == OFS_STATUS) begin
      sel_stat = 1'b1;
    end else if (paddr[7:0] == OFS_FSEL) begin
      sel_fsel = 1'b1;
    end else if (paddr[7:0] == OFS_PC_LATCH) begin
      sel_latch = 1'b1;
    end else if (paddr[7:0] == OFS_PC_VIEW) begin
      sel_view = 1'b1;
    end
  end

  assign sel_any = sel_ind | sel_pcl | sel_stat | sel_fsel | sel_latch |
                   sel_view;
  assign setup_ph = psel & ~penable;

  ////////////////////////////////////////////////////////////////////////////
  // Access-phase wait counter; every transfer answers after two waits.

  logic [1:0] acc_q;
  logic [1:0] acc_d;

  assign done = psel & penable & (acc_q == ACC_WAIT);
  assign wr_done = done & pwrite;
  assign pready = done;
  assign pslverr = done & ~sel_any;

  always_comb begin
    acc_d = acc_q;
    if (done) begin
      acc_d = 2'h0;
    end else if (psel & penable) begin
      acc_d = acc_q + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 2'h0;
    end else begin
      acc_q <= acc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers.

  logic [7:0] fsel_q;
  logic [7:0] fsel_d;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [LATCH_W-1:0] latch_q;
  logic [LATCH_W-1:0] latch_d;

  assign ind_addr = {status_q[STATUS_BANK_POS], fsel_q};
  assign ind_self = (fsel_q == SELF_ADDR);

  always_comb begin
    fsel_d = fsel_q;
    status_d = status_q;
    latch_d = latch_q;
    if (wr_done & sel_fsel) begin
      fsel_d = pwdata[7:0];
    end
    if (wr_done & sel_stat) begin
      status_d = pwdata[7:0];
    end
    if (wr_done & sel_latch) begin
      latch_d = pwdata[LATCH_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_q <= FSEL_RESET;
      status_q <= STATUS_RESET;
      latch_q <= LATCH_RESET;
    end else begin
      fsel_q <= fsel_d;
      status_q <= status_d;
      latch_q <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and stack requests; a bus write to the low byte wins
  // over a decoder op in the same cycle.

  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] jump_target;

  assign jump_target = {latch_q[LATCH_W-1:LATCH_TOP_POS],
                        op_literal};

  always_comb begin
    pc_d = pc_q;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_q;
    if (wr_done & sel_pcl) begin
      pc_d = {latch_q, pwdata[7:0]};
    end else if (op_valid) begin
      case (op_code)
        OP_STEP: begin
          pc_d = pc_q + PC_ONE;
        end
        OP_CALL: begin
          push = 1'b1;
          push_data = pc_q + PC_ONE;
          pc_d = jump_target;
        end
        OP_JUMP: begin
          pc_d = jump_target;
        end
        OP_RET, OP_RETLIT, OP_RETINT: begin
          pop = 1'b1;
          pc_d = st.top;
        end
        OP_INTR: begin
          push = 1'b1;
          push_data = pc_q;
          pc_d = INT_VECTOR;
        end
        default: begin
          pc_d = pc_q;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  assign st.push = push;
  assign st.pop = pop;
  assign st.push_data = push_data;
  assign pc = pc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Data memory strobes for the indirect port.

  logic [DADDR_W-1:0] maddr_q;
  logic [DADDR_W-1:0] maddr_d;
  logic mrd_q;
  logic mrd_d;
  logic mwr_q;
  logic mwr_d;
  logic [7:0] mwdata_q;
  logic [7:0] mwdata_d;

  always_comb begin
    maddr_d = maddr_q;
    mrd_d = 1'b0;
    mwr_d = 1'b0;
    mwdata_d = mwdata_q;
    if (setup_ph & sel_ind) begin
      maddr_d = ind_addr;
      mrd_d = ~pwrite & ~ind_self;
    end
    if (wr_done & sel_ind & ~ind_self) begin
      mwr_d = 1'b1;
      maddr_d = ind_addr;
      mwdata_d = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_q <= 9'h000;
      mrd_q <= 1'b0;
      mwr_q <= 1'b0;
      mwdata_q <= ZERO_BYTE;
    end else begin
      maddr_q <= maddr_d;
      mrd_q <= mrd_d;
      mwr_q <= mwr_d;
      mwdata_q <= mwdata_d;
    end
  end

  assign mem_addr = maddr_q;
  assign mem_rd = mrd_q;
  assign mem_wr = mwr_q;
  assign mem_wdata = mwdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured on the last wait cycle.

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  always_comb begin
    prdata_d = prdata_q;
    if (psel & penable & (acc_q == 2'h1) & ~pwrite) begin
      prdata_d = 32'h00000000;
      if (sel_ind) begin
        prdata_d[7:0] = ind_self ? ZERO_BYTE : mem_rdata;
      end else if (sel_pcl) begin
        prdata_d[7:0] = pc_q[7:0];
      end else if (sel_stat) begin
        prdata_d[7:0] = status_q;
      end else if (sel_fsel) begin
        prdata_d[7:0] = fsel_q;
      end else if (sel_latch) begin
        prdata_d[LATCH_W-1:0] = latch_q;
      end else if (sel_view) begin
        prdata_d[PC_W-1:0] = pc_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule

/* File: pcflow_core_asserts.sv */
// Concurrent checks on the ports of the program-flow core.
// Assumes one clock pclk and the asynchronous active-low reset presetn.
`timescale 1ns/100ps
module pcflow_core_asserts
  import pcflow_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic op_valid,
  input wire flow_op_t op_code,
  input wire logic [LIT_W-1:0] op_literal,
  input wire logic [PC_W-1:0] pc,
  input wire logic [DADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  sequence s_setup; psel && !penable; endsequence
  sequence s_call; op_valid && op_code == OP_CALL; endsequence
  sequence s_ret; op_valid && op_code == OP_RET; endsequence
  sequence s_low_wr;
    psel && penable && pready && pwrite && paddr == 32'h4;
  endsequence
  chk_first_pc: assert property ($rose(presetn) |-> pc == PC_RESET)
    else $error("pc not zero after reset");
  chk_step_inc: assert property (op_valid && op_code == OP_STEP
    |=> pc == $past(pc) + PC_ONE) else $error("step wrong");
  chk_jump_low: assert property (op_valid && op_code == OP_JUMP
    |=> pc[10:0] == $past(op_literal)) else $error("jump wrong");
  chk_intr_vec: assert property (op_valid && op_code == OP_INTR
    |=> pc == INT_VECTOR) else $error("vector wrong");
  chk_call_ret: assert property (s_call ##1 s_ret
    |=> pc == $past(pc, 2) + PC_ONE) else $error("return wrong");
  chk_bus_wait: assert property (s_setup
    |=> !pready ##1 !pready ##1 pready) else $error("ready late");
  chk_low_load: assert property (s_low_wr
    |=> pc[7:0] == $past(pwdata[7:0])) else $error("low load wrong");
  chk_self_drop: assert property (mem_wr |-> mem_addr[7:0] != SELF_ADDR)
    else $error("self write stored");
  chk_wr_data: assert property (mem_wr
    |-> mem_wdata == $past(pwdata[7:0])) else $error("write data wrong");
endmodule
bind pcflow_core pcflow_core_asserts chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .op_valid(op_valid),
  .op_code(op_code),
  .op_literal(op_literal),
  .pc(pc),
  .mem_addr(mem_addr),
  .mem_wr(mem_wr),
  .mem_wdata(mem_wdata)
);

/* File: data_mem_model.sv */
// Behavioural data memory behind the indirect port.
// Assumes a registered read strobe and one cycle of read latency.
`timescale 1ns/100ps
module data_mem_model (
  input wire logic pclk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [512];
  initial begin
    mem_rdata = 8'h00;
    for (int i = 0; i < 512; i++) begin
      m[i] = i[7:0] ^ 8'h5A;
    end
  end
  // Read data is valid one cycle after a read; otherwise it toggles.
  always @(posedge pclk) begin
    if (mem_wr) begin
      m[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem_rd ? m[mem_addr] : ~mem_rdata;
  end
endmodule

/* File: pcflow_core_tb.sv */
// Self-checking bench for the program-flow core over APB and decoder ops.
// Assumes the core, its bound checker and the behavioural data memory.
`timescale 1ns/100ps
module pcflow_core_tb;
  import pcflow_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic op_valid = 1'b0;
  flow_op_t op_code = OP_NONE;
  logic [LIT_W-1:0] op_literal = 11'h000;
  logic [PC_W-1:0] pc;
  logic [DADDR_W-1:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  int n_mismatch = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic err;
  logic [PC_W-1:0] pushed [9];
  logic [PC_W-1:0] cur;
  always #4 pclk = ~pclk;
  pcflow_core dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .op_valid(op_valid),
    .op_code(op_code),
    .op_literal(op_literal),
    .pc(pc),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );
  data_mem_model mem_u (
    .pclk(pclk),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );
  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Counts: %0d mismatches, %0d compares", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic op(input flow_op_t c, input logic [10:0] l);
    op_valid <= 1'b1;
    op_code <= c;
    op_literal <= l;
    @(posedge pclk);
  endtask
  task automatic idle();
    op_valid <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp("pc reset", 32'(PC_RESET), 32'(pc));
    apb(1'b1, 32'h10, 32'h15);
    apb(1'b1, 32'h04, 32'h3C);
    cmp("pc load", 32'h153C, 32'(pc));
    apb(1'b0, 32'h04, 32'h0);
    cmp("low byte", 32'h3C, rd);
    op(OP_JUMP, 11'h7AB);
    op(OP_STEP, 11'h000);
    idle();
    cur = 13'h17AC;
    cmp("jump step", 32'(cur), 32'(pc));
    apb(1'b1, 32'h14, 32'h1FFF);
    apb(1'b0, 32'h14, 32'h0);
    cmp("pc view", 32'h17AC, rd);
    $display("Test pc load done");
    for (int i = 0; i < 9; i++) begin
      pushed[i] = cur + PC_ONE;
      cur = {2'b10, 11'h100 + 11'(i)};
      op(OP_CALL, cur[10:0]);
      idle();
      cmp("call", 32'(cur), 32'(pc));
    end
    for (int i = 0; i < 9; i++) begin
      op(flow_op_t'(OP_RET + i % 3), 11'h000);
      idle();
      cmp("return", 32'(pushed[i == 8 ? 8 : 8 - i]), 32'(pc));
    end
    apb(1'b0, 32'h10, 32'h0);
    cmp("latch", 32'h15, rd);
    op(OP_CALL, 11'h055);
    op(OP_RET, 11'h000);
    op(OP_INTR, 11'h000);
    idle();
    cmp("vector", 32'(INT_VECTOR), 32'(pc));
    op(OP_RETINT, 11'h000);
    idle();
    cmp("interrupt return", 32'(pushed[8] + PC_ONE), 32'(pc));
    $display("Test stack done");
    apb(1'b1, 32'h08, 32'h80);
    apb(1'b1, 32'h0C, 32'h40);
    apb(1'b0, 32'h0C, 32'h0);
    cmp("pointer", 32'h40, rd);
    apb(1'b1, 32'h00, 32'hA7);
    apb(1'b0, 32'h00, 32'h0);
    cmp("indirect read", 32'hA7, rd);
    cmp("bank one cell", 32'hA7, 32'(mem_u.m[9'h140]));
    apb(1'b1, 32'h08, 32'h00);
    apb(1'b0, 32'h00, 32'h0);
    cmp("bank zero read", 32'h1A, rd);
    apb(1'b1, 32'h0C, 32'h00);
    apb(1'b1, 32'h00, 32'hEE);
    apb(1'b0, 32'h00, 32'h0);
    cmp("self read", 32'h0, rd);
    cmp("self cell", 32'h5A, 32'(mem_u.m[0]));
    apb(1'b0, 32'h100, 32'h0);
    cmp("unmapped error", 32'h1, 32'(err));
    apb(1'b1, 32'h04, 32'hFF);
    apb(1'b1, 32'h10, 32'h16);
    apb(1'b1, 32'h04, 32'h02);
    cmp("computed wrap", 32'h1602, 32'(pc));
    presetn <= 1'b0;
    @(posedge pclk);
    cmp("pc second reset", 32'(PC_RESET), 32'(pc));
    presetn <= 1'b1;
    @(posedge pclk);
    op(OP_JUMP, 11'h123);
    idle();
    cmp("jump after reset", 32'h0123, 32'(pc));
    $display("Test indirect done");
    stop_test();
  end
endmodule
